// File: common/aocr_map.svh
// Register map of the output configuration bank: offsets, fields, resets.
// Assumes an 8-bit register address and 8-bit data from the serial port.
`ifndef AOCR_MAP_SVH
`define AOCR_MAP_SVH
`define AOCR_OFS_DATA_OUT   8'h14
`define AOCR_OFS_DRIVE      8'h15
`define AOCR_OFS_CLK_PHASE  8'h16
`define AOCR_OFS_DELAY      8'h17
`define AOCR_OFS_RANGE      8'h18
`define AOCR_OFS_OVR        8'h2a
`define AOCR_OFS_UPDATE     8'hff
`define AOCR_RST_DATA_OUT   8'h00
`define AOCR_RST_DRIVE      8'h00
`define AOCR_RST_CLK_PHASE  8'h03
`define AOCR_RST_DELAY      8'h00
`define AOCR_RST_RANGE      8'h00
`define AOCR_RST_OVR        8'h01
`define AOCR_MSK_DATA_OUT   8'h1f
`define AOCR_MSK_DRIVE      8'h0f
`define AOCR_MSK_CLK_PHASE  8'h80
`define AOCR_MSK_DELAY      8'h9f
`define AOCR_MSK_RANGE      8'h1f
`define AOCR_MSK_OVR        8'h03
`define AOCR_MSK_UPDATE     8'h01
`define AOCR_BIT_INVERT     2
`define AOCR_BIT_DDR        3
`define AOCR_BIT_OUT_DIS    4
`define AOCR_BIT_COARSE     3
`define AOCR_BIT_CLK_INV    7
`define AOCR_BIT_DLY_BYP    7
`define AOCR_BIT_OVR_EN     0
`define AOCR_BIT_OVR_POS    1
`define AOCR_BIT_COMMIT     0
`endif

// File: common/aocr_pkg.sv
// Types shared by the output configuration bank.
// Assumes aocr_map.svh supplies offsets and field positions.
package aocr_pkg;
  typedef enum logic [1:0] {
    AOCR_FMT_OFFSET_BIN,
    AOCR_FMT_TWOS_COMP,
    AOCR_FMT_GRAY,
    AOCR_FMT_RESERVED
  } aocr_fmt_e;
  typedef logic [7:0] aocr_byte_t;
endpackage : aocr_pkg

// File: src/aocr_regs.sv
// Output configuration register bank with staged and active copies.
// Assumes the serial port logic delivers one-cycle write strobes and
// samples read data combinationally, all on clk.
// Operation
// - Format code 00 offset binary, 01 twos complement, 10 Gray; reset 00
// - Invert bit 1 inverts output data word; 0 passes it
// - DDR bit 1 selects double data rate; 0 single rate
// - Output disable bit 0 enables drivers; 1 disables them
// - Clock phase MSB 1 inverts output clock polarity
// - Delay register top bit 0 enables delay, 1 bypasses it
// - Five-bit delay amount; all ones is maximum 3.2 ns
// - Five-bit signed range trim; 00000 nominal, 10000 min, 01111 max
// - Overrange bit 0 enables indicator, reset on
// - Overrange bit 1 picks pin pair, only in DDR mode
// - Coarse drive bit 0 gives 3.5 mA, 1 gives 2.0 mA
// - Fine drive codes 001..111 step 3.50 down to 2.00 mA
// - Writes take effect only when commit bit copies staged to active
`include "aocr_map.svh"
module aocr_regs
  import aocr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register access from serial port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  // Active output configuration
  output aocr_fmt_e       data_format,
  output logic            data_invert,
  output logic            ddr_mode,
  output logic            out_drv_en,
  output logic            clk_invert,
  output logic            delay_enable,
  output logic      [4:0] delay_amount,
  output logic      [4:0] range_trim,
  output logic            ovr_enable,
  output logic            ovr_alt_pins,
  output logic            drive_reduced,
  output logic      [2:0] drive_fine
);

  // Staged (master) and active (slave) copies, six registers each
  aocr_byte_t stage [6];
  aocr_byte_t act   [6];
  aocr_byte_t next_stage [6];
  aocr_byte_t next_act   [6];

  // Next values of the field outputs
  aocr_fmt_e  next_data_format;
  logic       next_data_invert;
  logic       next_ddr_mode;
  logic       next_out_drv_en;
  logic       next_clk_invert;
  logic       next_delay_enable;
  logic [4:0] next_delay_amount;
  logic [4:0] next_range_trim;
  logic       next_ovr_enable;
  logic       next_ovr_alt_pins;
  logic       next_drive_reduced;
  logic [2:0] next_drive_fine;

  function automatic logic [2:0] idx_of(input logic [7:0] a);
    unique case (a)
      `AOCR_OFS_DATA_OUT:  idx_of = 3'd0;
      `AOCR_OFS_DRIVE:     idx_of = 3'd1;
      `AOCR_OFS_CLK_PHASE: idx_of = 3'd2;
      `AOCR_OFS_DELAY:     idx_of = 3'd3;
      `AOCR_OFS_RANGE:     idx_of = 3'd4;
      `AOCR_OFS_OVR:       idx_of = 3'd5;
      default:             idx_of = 3'd7;
    endcase
  endfunction : idx_of

  function automatic aocr_byte_t mask_of(input logic [2:0] i);
    unique case (i)
      3'd0:    mask_of = `AOCR_MSK_DATA_OUT;
      3'd1:    mask_of = `AOCR_MSK_DRIVE;
      3'd2:    mask_of = `AOCR_MSK_CLK_PHASE;
      3'd3:    mask_of = `AOCR_MSK_DELAY;
      3'd4:    mask_of = `AOCR_MSK_RANGE;
      3'd5:    mask_of = `AOCR_MSK_OVR;
      default: mask_of = 8'h00;
    endcase
  endfunction : mask_of

  function automatic aocr_byte_t rst_of(input int i);
    unique case (i)
      0:       rst_of = `AOCR_RST_DATA_OUT;
      1:       rst_of = `AOCR_RST_DRIVE;
      2:       rst_of = `AOCR_RST_CLK_PHASE;
      3:       rst_of = `AOCR_RST_DELAY;
      4:       rst_of = `AOCR_RST_RANGE;
      default: rst_of = `AOCR_RST_OVR;
    endcase
  endfunction : rst_of

  // Reset image of one register, fixed-zero bits already cleared
  function automatic aocr_byte_t rst_val(input int i);
    rst_val = rst_of(i) & mask_of(3'(i));
  endfunction : rst_val

  logic [2:0] widx;
  logic       commit;

  // Staging group: host writes land here at once
  always_comb begin
    widx = idx_of(wr_addr);
    for (int i = 0; i < 6; i++) begin
      if (rst) begin
        next_stage[i] = rst_val(i);
      end else if (wr_en && widx == 3'(i)) begin
        // Fixed-zero bits never store
        next_stage[i] = wr_data & mask_of(3'(i));
      end else begin
        next_stage[i] = stage[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      stage[i] <= next_stage[i];
    end
  end

  // Active group: moves only on commit or reset, so a half-written setup
  // never reaches the output path
  always_comb begin
    // Commit bit is self-clearing, so the update register holds nothing
    commit = wr_en && (wr_addr == `AOCR_OFS_UPDATE)
             && wr_data[`AOCR_BIT_COMMIT];
    for (int i = 0; i < 6; i++) begin
      if (rst) begin
        next_act[i] = rst_val(i);
      end else if (commit) begin
        // Whole staged copy moves; a write in the same cycle waits
        next_act[i] = stage[i];
      end else begin
        next_act[i] = act[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      act[i] <= next_act[i];
    end
  end

  // Readback shows the staged copy, so the host can check before commit
  logic [2:0] ridx;
  always_comb begin
    ridx = idx_of(rd_addr);
    if (ridx < 3'd6) begin
      rd_data = stage[ridx] & mask_of(ridx);
    end else begin
      rd_data = 8'h00;
    end
  end

  // Field outputs are flops fed from the next active copy, so they
  // move on the commit edge together with the slave copy
  // Data word group
  always_comb begin
    next_data_format = aocr_fmt_e'(next_act[0][1:0]);
    next_data_invert = next_act[0][`AOCR_BIT_INVERT];
    next_ddr_mode    = next_act[0][`AOCR_BIT_DDR];
    next_out_drv_en  = ~next_act[0][`AOCR_BIT_OUT_DIS];
  end

  always_ff @(posedge clk) begin
    data_format <= next_data_format;
    data_invert <= next_data_invert;
    ddr_mode    <= next_ddr_mode;
    out_drv_en  <= next_out_drv_en;
  end

  // Clock and delay group
  always_comb begin
    next_clk_invert   = next_act[2][`AOCR_BIT_CLK_INV];
    next_delay_enable = ~next_act[3][`AOCR_BIT_DLY_BYP];
    next_delay_amount = next_act[3][4:0];
  end

  always_ff @(posedge clk) begin
    clk_invert   <= next_clk_invert;
    delay_enable <= next_delay_enable;
    delay_amount <= next_delay_amount;
  end

  // Drive and range group
  always_comb begin
    next_drive_reduced = next_act[1][`AOCR_BIT_COARSE];
    next_drive_fine    = next_act[1][2:0];
    next_range_trim    = next_act[4][4:0];
  end

  always_ff @(posedge clk) begin
    drive_reduced <= next_drive_reduced;
    drive_fine    <= next_drive_fine;
    range_trim    <= next_range_trim;
  end

  // Overrange group
  always_comb begin
    next_ovr_enable   = next_act[5][`AOCR_BIT_OVR_EN];
    // Pin pair choice is meaningless in single rate mode
    next_ovr_alt_pins = next_act[0][`AOCR_BIT_DDR]
                        & next_act[5][`AOCR_BIT_OVR_POS];
  end

  always_ff @(posedge clk) begin
    ovr_enable   <= next_ovr_enable;
    ovr_alt_pins <= next_ovr_alt_pins;
  end

endmodule : aocr_regs

// File: tb/aocr_host.sv
// Host model that issues register writes and reads.
// Assumes the bank samples wr_en on rising clk.
module aocr_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic      [7:0] wr_addr, wr_data, rd_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {wr_en, wr_addr, wr_data, rd_addr} = '0;
  task wr(input logic [7:0] a, d);
    @(posedge clk) {wr_en, wr_addr, wr_data} <= {1'b1, a, d};
    @(posedge clk) wr_en <= 1'b0;
  endtask : wr
  // Address is left in place so the checker can see it
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) rd_addr <= a;
    @(posedge clk) #1 d = rd_data;
  endtask : rd
endmodule : aocr_host

// File: tb/aocr_regs_monitor.sv
// Checker on the ports of the output configuration bank.
// Assumes the staged copy is seen through rd_data at rd_addr.
module aocr_regs_monitor
  import aocr_pkg::*;
(
  input wire logic       clk, rst, wr_en,
  input wire logic [7:0] wr_addr, wr_data, rd_addr, rd_data,
  input wire aocr_fmt_e  data_format,
  input wire logic       data_invert, ddr_mode, out_drv_en, clk_invert,
  input wire logic       delay_enable, ovr_enable, ovr_alt_pins,
  input wire logic       drive_reduced,
  input wire logic [4:0] delay_amount, range_trim,
  input wire logic [2:0] drive_fine
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cm;
  assign cm = wr_en && wr_addr == 8'hff && wr_data[0];
  AST_HOLD: assert property (!cm |=>
    $stable({data_format, ddr_mode, delay_amount, drive_fine}))
    else $error("active copy moved without commit");
  AST_FMT: assert property (cm && rd_addr == 8'h14 |=>
    data_format == $past(rd_data[1:0]) && data_invert == $past(rd_data[2]))
    else $error("format or invert not applied");
  AST_DDR: assert property (cm && rd_addr == 8'h14 |=>
    ddr_mode == $past(rd_data[3]) && out_drv_en == !$past(rd_data[4]))
    else $error("rate or driver enable not applied");
  AST_DLY: assert property (cm && rd_addr == 8'h17 |=>
    delay_enable == !$past(rd_data[7]) && delay_amount == $past(rd_data[4:0]))
    else $error("delay not applied");
  AST_DRV: assert property (cm && rd_addr == 8'h15 |=>
    drive_reduced == $past(rd_data[3]) && drive_fine == $past(rd_data[2:0]))
    else $error("drive not applied");
  AST_OVR: assert property (ovr_alt_pins |-> ddr_mode)
    else $error("alternate pins outside double rate");
  AST_RST: assert property ($fell(rst) |->
    out_drv_en && delay_enable && ovr_enable && !ddr_mode)
    else $error("wrong active reset values");
  AST_RD: assert property (rd_addr == 8'hff |-> rd_data == 8'h00)
    else $error("commit register reads nonzero");
endmodule : aocr_regs_monitor
bind aocr_regs aocr_regs_monitor mon_inst (.*);

// File: tb/aocr_regs_bench.sv
// Self-checking bench for the output configuration bank.
// Assumes all register traffic goes through the host model.
module aocr_regs_bench
  import aocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, rst = 1'b1, wr_en, data_invert, ddr_mode;
  logic       out_drv_en, clk_invert, delay_enable, ovr_enable;
  logic       ovr_alt_pins, drive_reduced;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, v;
  logic [4:0] delay_amount, range_trim;
  logic [2:0] drive_fine;
  aocr_fmt_e  data_format;
  int         failures, comparisons, cyc;
  logic [7:0] ra [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h2a, 8'h20,
                         8'hff};
  aocr_regs aocr_regs_inst (.*);
  aocr_host aocr_host_inst (.*);
  initial forever #12.5 clk = ~clk;
  task chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task stage(input logic [7:0] a, d, e);
    aocr_host_inst.wr(a, d);
    aocr_host_inst.rd(a, v);
    chk(v, e);
    aocr_host_inst.wr(8'hff, 8'h01);
    #1;
  endtask : stage
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      aocr_host_inst.rd(ra[i], v);
      chk(v, {7'h00, ra[i] == 8'h2a});
    end
    chk({3'h0, out_drv_en, delay_enable, ovr_enable, ddr_mode, clk_invert},
        8'h1c);
    stage(8'h14, 8'hff, 8'h1f);
    chk({3'h0, data_format, data_invert, ddr_mode, out_drv_en}, 8'h1e);
    aocr_host_inst.wr(8'h14, 8'h00);
    aocr_host_inst.wr(8'hff, 8'hfe);
    #1 chk({7'h0, ddr_mode}, 8'h01);
    for (int f = 0; f < 3; f++) begin
      stage(8'h14, 8'(f), 8'(f));
      chk({6'h0, data_format}, 8'(f));
    end
    stage(8'h2a, 8'h03, 8'h03);
    chk({7'h0, ovr_alt_pins}, 8'h00);
    stage(8'h14, 8'h08, 8'h08);
    chk({6'h0, ovr_alt_pins, ovr_enable}, 8'h03);
    stage(8'h17, 8'h9f, 8'h9f);
    stage(8'h15, 8'hff, 8'h0f);
    stage(8'h18, 8'h10, 8'h10);
    stage(8'h16, 8'hff, 8'h80);
    chk({range_trim, drive_fine}, 8'h87);
    chk({delay_enable, drive_reduced, clk_invert, delay_amount},
        8'h7f);
    stage(8'h2a, 8'h00, 8'h00);
    chk({6'h0, ovr_alt_pins, ovr_enable}, 8'h00);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    aocr_host_inst.rd(8'h17, v);
    chk(v, 8'h00);
    chk({5'h0, delay_enable, out_drv_en, ovr_enable}, 8'h07);
    wrap_up();
  end
endmodule : aocr_regs_bench
